// >>> rtl/pom_pkg.sv
package pom_pkg;
  // Counts of fast, slow and all pins
  localparam int NFAST = 8;
  localparam int NSLOW = 4;
  localparam int NPIN = 12;
  // Clock and source rates
  localparam int CLK_HZ = 100000000;
  localparam int PWM1_HZ = 10000;
  localparam int PWM2_HZ = 1000;
  localparam logic [31:0] FAST_SRC_HZ = 32'h0EE6B280;
  localparam logic [31:0] SLOW_SRC_HZ = 32'h00EE6B28;
  // Half source ticks per hclk for the fast counters (2 x 250 / 100)
  localparam logic [15:0] FSTEP = 16'(2 * 250000000 / CLK_HZ);
  // Slow source tick: phase accumulator, 15.625 MHz = 5/32 of hclk
  localparam logic [5:0] SACC_INC = 6'(15625000 * 32 / CLK_HZ);
  // Divider limits
  localparam logic [31:0] FDIV_MIN = 32'h00000002;
  localparam logic [31:0] FDIV_MAX = 32'h00003FFF;
  localparam logic [31:0] SDIV_MIN = 32'h00000002;
  localparam logic [31:0] SDIV_MAX = 32'h00FFFFFF;
  localparam logic [17:0] MDUTY_MAX = 18'h3FFFF;
  // Pin modes
  localparam logic [2:0] PM_UNUSED = 3'h0;
  localparam logic [2:0] PM_GPI = 3'h1;
  localparam logic [2:0] PM_GPO_PP = 3'h2;
  localparam logic [2:0] PM_GPO_OD = 3'h3;
  localparam logic [2:0] PM_PWM = 3'h4;
  localparam logic [2:0] PM_MRG_CL = 3'h5;
  localparam logic [2:0] PM_MRG_UP = 3'h6;
  localparam logic [2:0] PM_MRG_DN = 3'h7;
  // Margin commands and closed-loop modes
  localparam logic [1:0] OP_OFF = 2'h0;
  localparam logic [1:0] OP_LOW = 2'h1;
  localparam logic [1:0] CL_DISABLE = 2'h0;
  localparam logic [1:0] CL_TRISTATE = 2'h1;
  localparam logic [1:0] CL_TRIM = 2'h2;
  localparam logic [1:0] CL_FIXED = 2'h3;
  localparam logic [3:0] PIN_NONE = 4'hF;
  // Register byte offsets
  localparam logic [7:0] R_MODE_FAST = 8'h00;
  localparam logic [7:0] R_MODE_SLOW = 8'h04;
  localparam logic [7:0] R_GPO = 8'h08;
  localparam logic [7:0] R_PIN_IN = 8'h0C;
  localparam logic [7:0] R_MRG_CTRL = 8'h10;
  localparam logic [7:0] R_MRG_LOW = 8'h14;
  localparam logic [7:0] R_MRG_HIGH = 8'h18;
  localparam logic [7:0] R_MRG_NOM = 8'h1C;
  localparam logic [7:0] R_MRG_FIXED = 8'h20;
  localparam logic [7:0] R_MRG_STAT = 8'h24;
  localparam logic [7:0] R_STATUS = 8'h28;
  localparam logic [7:0] R_FAST_DUTY = 8'h40;
  localparam logic [7:0] R_FAST_PHASE = 8'h60;
  localparam logic [7:0] R_SLOW_DUTY = 8'h80;
  localparam logic [7:0] R_FAST_FREQ = 8'hA0;
  localparam logic [7:0] R_SLOW_FREQ = 8'hB0;
  // Reset values
  localparam logic [13:0] RST_FDIV = 14'h3FFF;
  localparam logic [23:0] RST_SDIV = 24'hFFFFFF;
  localparam logic [3:0] RST_PIN_SEL = 4'hF;
  // Frequency divider sequencer, one-hot
  typedef enum logic [2:0] {DV_IDLE = 3'b001, DV_LOAD = 3'b010, DV_RUN = 3'b100} pom_dv_e;
  // Margin control fields
  typedef struct packed {
    logic [3:0] dn_sel;
    logic [3:0] en_sel;
    logic dir;
    logic [1:0] clmode;
    logic [1:0] op;
  } pom_mcfg_s;
  // Whole state of the block
  typedef struct packed {
    logic [7:0][2:0] mode_f;
    logic [3:0][2:0] mode_s;
    logic [11:0] general_output_pin;
    logic [11:0] sync1;
    logic [11:0] sync2;
    pom_mcfg_s mcfg;
    logic [15:0] tgt_lo;
    logic [15:0] tgt_hi;
    logic [15:0] nom;
    logic [17:0] fixed;
    logic [17:0] mduty;
    logic [3:0][13:0] fdiv;
    logic [3:0][13:0] fdiv_a;
    logic [3:0][14:0] fcnt;
    logic [7:0][17:0] fduty;
    logic [7:0][13:0] fphase;
    logic [7:0][17:0] fduty_a;
    logic [7:0][13:0] fphase_a;
    logic [1:0][23:0] sdiv;
    logic [3:0][23:0] sdiv_a;
    logic [3:0][23:0] scnt;
    logic [3:0][15:0] sduty;
    logic [3:0][23:0] sthr;
    logic [4:0] sacc;
    pom_dv_e dv;
    logic [4:0] dcnt;
    logic [2:0] dsel;
    logic [31:0] dnum;
    logic [31:0] dden;
    logic [32:0] drem;
    logic [31:0] dq;
    logic a_act;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [11:0] pout;
    logic [11:0] poe_n;
  } pom_state_s;
endpackage

// >>> rtl/pom_top.sv
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pom_top
  import pom_pkg::*;
#(
  parameter logic [23:0] PWM1_DIV = 24'(CLK_HZ / PWM1_HZ),
  parameter logic [23:0] PWM2_DIV = 24'(CLK_HZ / PWM2_HZ),
  parameter logic [17:0] MRG_STEP = 18'h00010
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [11:0] pin_in,
  output logic [11:0] pin_out,
  output logic [11:0] pin_oe_n,
  input wire logic [15:0] rail_mv,
  input wire logic rail_valid
);
  pom_state_s s_r; // Registered state
  pom_state_s s_nxt; // Next state

  // Remove one period when the value has reached or passed it
  function automatic logic [15:0] sub_mod(input logic [15:0] v, input logic [15:0] m);
    return (v >= m) ? v - m : v;
  endfunction

  // Fast output level from counter, phase offset and duty in sixteenths
  function automatic logic fast_high(input logic [14:0] c, input logic [13:0] dv, input logic [13:0] ph,
                                     input logic [17:0] du);
    logic [15:0] pos;
    logic [15:0] per;
    per = {1'b0, dv, 1'b0};
    pos = {1'b0, c} + {1'b0, ph, 1'b0};
    pos = sub_mod(pos, per);
    pos = sub_mod(pos, per);
    return {pos, 3'b000} < {1'b0, du};
  endfunction

  // Slow compare threshold: duty fraction of 65536 times period
  function automatic logic [23:0] slow_thr(input logic [15:0] du, input logic [23:0] dv);
    logic [39:0] p;
    p = du * dv;
    return p[39:16];
  endfunction

  // Clamp a quotient into a divider range
  function automatic logic [31:0] clampq(input logic [31:0] q, input logic [31:0] lo, input logic [31:0] hi);
    return (q < lo) ? lo : ((q > hi) ? hi : q);
  endfunction

  // One trim step toward the target, saturating
  function automatic logic [17:0] mstep(input logic [17:0] du, input logic [15:0] meas, input logic [15:0] tgt,
                                        input logic dir, input logic [17:0] st);
    if (meas == tgt) begin
      return du;
    end
    if ((meas < tgt) ^ dir) begin
      return (du > MDUTY_MAX - st) ? MDUTY_MAX : du + st;
    end
    return (du < st) ? 18'h00000 : du - st;
  endfunction

  logic acc; // Address phase taken this cycle
  logic is_freq; // Address phase names a frequency register
  logic [31:0] rd; // Read data for the taken address
  logic [15:0] nc; // Fast counter candidate
  logic fw; // Fast pair wrap
  logic [5:0] sa; // Slow accumulator sum
  logic [24:0] sc; // Slow counter candidate
  logic [23:0] sdv; // Slow divider for the next period
  logic [32:0] rr; // Divider partial remainder
  logic [31:0] qq; // Divider quotient so far
  logic en_pin; // Margin enable from its input pin
  logic dn_pin; // Margin low-not-high from its input pin
  logic mrg_on; // Margining active
  logic mrg_low; // Margin toward the low target
  logic [2:0] md; // Effective pin mode
  logic [7:0] fh; // Fast output levels
  logic [3:0] sh; // Slow output levels

  // Next-state logic for bus, counters, margining and pins
  always_comb begin
    s_nxt = s_r;
    acc = hsel & hready & htrans[1];
    is_freq = (haddr[7:4] == R_FAST_FREQ[7:4]) | (haddr[7:3] == R_SLOW_FREQ[7:3]);
    rd = 32'h00000000;
    nc = 16'h0000;
    fw = 1'b0;
    sc = 25'h0000000;
    sdv = 24'h000000;
    rr = 33'h000000000;
    qq = 32'h00000000;
    md = PM_UNUSED;
    fh = 8'h00;
    sh = 4'h0;
    // Two-stage synchroniser for the pins
    s_nxt.sync1 = pin_in;
    s_nxt.sync2 = s_r.sync1;

    // Margin command: register first, else the two input pins
    en_pin = (s_r.mcfg.en_sel < 4'(NPIN)) ? s_r.sync2[s_r.mcfg.en_sel] : 1'b0;
    dn_pin = (s_r.mcfg.dn_sel < 4'(NPIN)) ? s_r.sync2[s_r.mcfg.dn_sel] : 1'b0;
    mrg_on = (s_r.mcfg.op != OP_OFF) | en_pin;
    mrg_low = (s_r.mcfg.op != OP_OFF) ? (s_r.mcfg.op == OP_LOW) : dn_pin;

    // Read mux, sampled in the address phase
    if (haddr[7:0] == R_MODE_FAST) begin
      rd = {8'h00, s_r.mode_f};
    end else if (haddr[7:0] == R_MODE_SLOW) begin
      rd = {20'h00000, s_r.mode_s};
    end else if (haddr[7:0] == R_GPO) begin
      rd = {20'h00000, s_r.general_output_pin};
    end else if (haddr[7:0] == R_PIN_IN) begin
      rd = {20'h00000, s_r.sync2};
    end else if (haddr[7:0] == R_MRG_CTRL) begin
      rd = {19'h00000, s_r.mcfg};
    end else if (haddr[7:0] == R_MRG_LOW) begin
      rd = {16'h0000, s_r.tgt_lo};
    end else if (haddr[7:0] == R_MRG_HIGH) begin
      rd = {16'h0000, s_r.tgt_hi};
    end else if (haddr[7:0] == R_MRG_NOM) begin
      rd = {16'h0000, s_r.nom};
    end else if (haddr[7:0] == R_MRG_FIXED) begin
      rd = {14'h0000, s_r.fixed};
    end else if (haddr[7:0] == R_MRG_STAT) begin
      rd = {12'h000, mrg_low, mrg_on, s_r.mduty};
    end else if (haddr[7:0] == R_STATUS) begin
      rd = {31'h00000000, s_r.dv != DV_IDLE};
    end else if (haddr[7:5] == R_FAST_DUTY[7:5]) begin
      rd = {14'h0000, s_r.fduty[haddr[4:2]]};
    end else if (haddr[7:5] == R_FAST_PHASE[7:5]) begin
      rd = {18'h00000, s_r.fphase[haddr[4:2]]};
    end else if (haddr[7:4] == R_SLOW_DUTY[7:4]) begin
      rd = {16'h0000, s_r.sduty[haddr[3:2]]};
    end else if (haddr[7:4] == R_FAST_FREQ[7:4]) begin
      rd = {18'h00000, s_r.fdiv[haddr[3:2]]};
    end else if (haddr[7:3] == R_SLOW_FREQ[7:3]) begin
      rd = {8'h00, s_r.sdiv[haddr[2]]};
    end

    // Address phase; frequency writes stall for the divider
    if (acc) begin
      s_nxt.a_act = 1'b1;
      s_nxt.a_wr = hwrite;
      s_nxt.a_addr = haddr[7:0];
      s_nxt.hrdata = rd;
      if (hwrite && is_freq) begin
        s_nxt.hready = 1'b0;
        s_nxt.dv = DV_LOAD;
      end
    end else if (s_r.hready) begin
      s_nxt.a_act = 1'b0;
    end

    // Data phase of a plain write
    if (s_r.a_act && s_r.a_wr && s_r.hready) begin
      if (s_r.a_addr == R_MODE_FAST) begin
        s_nxt.mode_f = hwdata[23:0];
      end else if (s_r.a_addr == R_MODE_SLOW) begin
        s_nxt.mode_s = hwdata[11:0];
      end else if (s_r.a_addr == R_GPO) begin
        s_nxt.general_output_pin = hwdata[11:0];
      end else if (s_r.a_addr == R_MRG_CTRL) begin
        s_nxt.mcfg = hwdata[12:0];
      end else if (s_r.a_addr == R_MRG_LOW) begin
        s_nxt.tgt_lo = hwdata[15:0];
      end else if (s_r.a_addr == R_MRG_HIGH) begin
        s_nxt.tgt_hi = hwdata[15:0];
      end else if (s_r.a_addr == R_MRG_NOM) begin
        s_nxt.nom = hwdata[15:0];
      end else if (s_r.a_addr == R_MRG_FIXED) begin
        s_nxt.fixed = hwdata[17:0];
      end else if (s_r.a_addr[7:5] == R_FAST_DUTY[7:5]) begin
        s_nxt.fduty[s_r.a_addr[4:2]] = hwdata[17:0];
      end else if (s_r.a_addr[7:5] == R_FAST_PHASE[7:5]) begin
        s_nxt.fphase[s_r.a_addr[4:2]] = hwdata[13:0];
      end else if (s_r.a_addr[7:4] == R_SLOW_DUTY[7:4]) begin
        s_nxt.sduty[s_r.a_addr[3:2]] = hwdata[15:0];
      end
    end

    // Frequency to divider: rounded quotient by restoring division
    case (s_r.dv)
      DV_LOAD: begin
        s_nxt.dsel = (s_r.a_addr[7:4] == R_FAST_FREQ[7:4]) ? {1'b0, s_r.a_addr[3:2]} : {2'b10, s_r.a_addr[2]};
        s_nxt.dnum = ((s_r.a_addr[7:4] == R_FAST_FREQ[7:4]) ? FAST_SRC_HZ : SLOW_SRC_HZ) + {1'b0, hwdata[31:1]};
        s_nxt.dden = hwdata;
        s_nxt.drem = 33'h000000000;
        s_nxt.dq = 32'h00000000;
        s_nxt.dcnt = 5'h00;
        s_nxt.dv = DV_RUN;
      end
      DV_RUN: begin
        rr = {s_r.drem[31:0], s_r.dnum[31]};
        qq = {s_r.dq[30:0], 1'b0};
        if (rr >= {1'b0, s_r.dden}) begin
          rr = rr - {1'b0, s_r.dden};
          qq[0] = 1'b1;
        end
        s_nxt.drem = rr;
        s_nxt.dq = qq;
        s_nxt.dnum = {s_r.dnum[30:0], 1'b0};
        s_nxt.dcnt = s_r.dcnt + 5'h01;
        if (s_r.dcnt == 5'h1F) begin
          // Store the clamped divider and end the wait state
          if (!s_r.dsel[2]) begin
            s_nxt.fdiv[s_r.dsel[1:0]] = 14'(clampq(qq, FDIV_MIN, FDIV_MAX));
          end else begin
            s_nxt.sdiv[s_r.dsel[0]] = 24'(clampq(qq, SDIV_MIN, SDIV_MAX));
          end
          s_nxt.hready = 1'b1;
          s_nxt.dv = DV_IDLE;
        end
      end
      default: begin
        if (!(acc && hwrite && is_freq)) begin
          s_nxt.dv = DV_IDLE;
        end
      end
    endcase

    // Closed-loop margining duty
    if (s_r.mcfg.clmode == CL_DISABLE) begin
      s_nxt.mduty = 18'h00000;
    end else if (mrg_on) begin
      if (rail_valid) begin
        s_nxt.mduty = mstep(s_r.mduty, rail_mv, mrg_low ? s_r.tgt_lo : s_r.tgt_hi, s_r.mcfg.dir, MRG_STEP);
      end
    end else if (s_r.mcfg.clmode == CL_TRIM) begin
      if (rail_valid) begin
        s_nxt.mduty = mstep(s_r.mduty, rail_mv, s_r.nom, s_r.mcfg.dir, MRG_STEP);
      end
    end else if (s_r.mcfg.clmode == CL_FIXED) begin
      s_nxt.mduty = s_r.fixed;
    end

    // Fast pairs: shared counter in half source ticks, 2.5 ticks per hclk
    for (int p = 0; p < 4; p++) begin
      nc = {1'b0, s_r.fcnt[p]} + FSTEP;
      fw = nc >= {1'b0, s_r.fdiv_a[p], 1'b0};
      nc = sub_mod(nc, {1'b0, s_r.fdiv_a[p], 1'b0});
      nc = sub_mod(nc, {1'b0, s_r.fdiv_a[p], 1'b0});
      if (fw) begin
        // Settings move to the active copy only at the period boundary
        s_nxt.fdiv_a[p] = s_r.fdiv[p];
        if (nc >= {1'b0, s_r.fdiv[p], 1'b0}) begin
          nc = 16'h0000;
        end
        for (int k = 2 * p; k < 2 * p + 2; k++) begin
          s_nxt.fduty_a[k] = (s_r.mode_f[k] == PM_MRG_CL) ? s_r.mduty : s_r.fduty[k];
          s_nxt.fphase_a[k] = s_r.fphase[k];
        end
      end
      s_nxt.fcnt[p] = nc[14:0];
    end
    for (int i = 0; i < NFAST; i++) begin
      fh[i] = fast_high(s_r.fcnt[i / 2], s_r.fdiv_a[i / 2], s_r.fphase_a[i], s_r.fduty_a[i]);
    end

    // Slow channels: 1 and 2 on hclk, 3 and 4 on the 15.625 MHz tick
    sa = {1'b0, s_r.sacc} + SACC_INC;
    s_nxt.sacc = sa[4:0];
    for (int c = 0; c < NSLOW; c++) begin
      if (c < 2 || sa[5]) begin
        sc = {1'b0, s_r.scnt[c]} + 25'h0000001;
        if (sc >= {1'b0, s_r.sdiv_a[c]}) begin
          sdv = (c == 0) ? PWM1_DIV : ((c == 1) ? PWM2_DIV : s_r.sdiv[c % 2]);
          s_nxt.sdiv_a[c] = sdv;
          s_nxt.sthr[c] = slow_thr(s_r.sduty[c], sdv);
          s_nxt.scnt[c] = 24'h000000;
        end else begin
          s_nxt.scnt[c] = sc[23:0];
        end
      end
      sh[c] = s_r.scnt[c] < s_r.sthr[c];
    end

    // Fast pin drivers; an unassigned partner joins an active pair
    for (int i = 0; i < NFAST; i++) begin
      md = s_r.mode_f[i];
      if (md == PM_UNUSED && s_r.mode_f[i ^ 1] == PM_PWM) begin
        md = PM_PWM;
      end
      case (md)
        PM_GPI: begin
          s_nxt.poe_n[i] = 1'b1;
          s_nxt.pout[i] = 1'b0;
        end
        PM_GPO_OD: begin
          s_nxt.poe_n[i] = s_r.general_output_pin[i];
          s_nxt.pout[i] = 1'b0;
        end
        PM_PWM: begin
          s_nxt.poe_n[i] = 1'b0;
          s_nxt.pout[i] = fh[i];
        end
        PM_MRG_CL: begin
          s_nxt.poe_n[i] = (s_r.mcfg.clmode == CL_TRISTATE) && !mrg_on;
          s_nxt.pout[i] = (s_r.mcfg.clmode != CL_DISABLE) && fh[i];
        end
        PM_MRG_UP: begin
          s_nxt.poe_n[i] = !(mrg_on && !mrg_low);
          s_nxt.pout[i] = 1'b0;
        end
        PM_MRG_DN: begin
          s_nxt.poe_n[i] = !(mrg_on && mrg_low);
          s_nxt.pout[i] = 1'b0;
        end
        default: begin
          // Unused or push-pull output: driven, low unless set
          s_nxt.poe_n[i] = 1'b0;
          s_nxt.pout[i] = s_r.general_output_pin[i];
        end
      endcase
    end

    // Slow pin drivers: PWM or input only
    for (int c = 0; c < NSLOW; c++) begin
      s_nxt.poe_n[NFAST + c] = s_r.mode_s[c] != PM_PWM;
      s_nxt.pout[NFAST + c] = (s_r.mode_s[c] == PM_PWM) && sh[c];
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.mcfg.en_sel <= RST_PIN_SEL;
      s_r.mcfg.dn_sel <= RST_PIN_SEL;
      s_r.fdiv <= {4{RST_FDIV}};
      s_r.fdiv_a <= {4{RST_FDIV}};
      s_r.sdiv <= {2{RST_SDIV}};
      s_r.sdiv_a <= {RST_SDIV, RST_SDIV, PWM2_DIV, PWM1_DIV};
      s_r.dv <= DV_IDLE;
      s_r.hready <= 1'b1;
      s_r.poe_n <= 12'hF00;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign hrdata = s_r.hrdata;
  assign hreadyout = s_r.hready;
  assign hresp = s_r.hresp;
  assign pin_out = s_r.pout;
  assign pin_oe_n = s_r.poe_n;

  property p_gpo_low;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.mode_f[0] == PM_GPO_PP && !s_r.general_output_pin[0]) |=> (!pin_oe_n[0] && !pin_out[0]);
  endproperty
  a_gpo_low: assert property (p_gpo_low) else $error("fast general output not driven low");

  property p_partner;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.mode_f[2] == PM_PWM && s_r.mode_f[3] == PM_UNUSED) |=> !pin_oe_n[3] && (pin_out[3] == $past(fh[3]));
  endproperty
  a_partner: assert property (p_partner) else $error("partner pin did not follow into PWM");

  property p_fdiv_range;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.fdiv_a[0] >= 14'(FDIV_MIN)) && (s_r.fdiv[1] >= 14'(FDIV_MIN));
  endproperty
  a_fdiv_range: assert property (p_fdiv_range) else $error("fast divider below two");

  property p_sdiv_range;
    @(posedge hclk) disable iff (!hresetn)
      s_r.sdiv[0] >= 24'(SDIV_MIN);
  endproperty
  a_sdiv_range: assert property (p_sdiv_range) else $error("slow divider below two");

  property p_fixed_rate;
    @(posedge hclk) disable iff (!hresetn)
      ##1 (s_r.sdiv_a[0] == PWM1_DIV) && (s_r.sdiv_a[1] == PWM2_DIV);
  endproperty
  a_fixed_rate: assert property (p_fixed_rate) else $error("fixed slow rate changed");

  property p_slow_in;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.mode_s[1] != PM_PWM) |=> pin_oe_n[NFAST + 1];
  endproperty
  a_slow_in: assert property (p_slow_in) else $error("slow pin not released as input");

  property p_tristate;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.mode_f[0] == PM_MRG_CL && s_r.mcfg.clmode == CL_TRISTATE && !mrg_on) |=> pin_oe_n[0];
  endproperty
  a_tristate: assert property (p_tristate) else $error("margin pin not released when idle");

  property p_fixed_duty;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.mcfg.clmode == CL_FIXED && !mrg_on) ##1 (s_r.mcfg.clmode == CL_FIXED && !mrg_on) |-> s_r.mduty == $past(s_r.fixed);
  endproperty
  a_fixed_duty: assert property (p_fixed_duty) else $error("fixed margin duty not held");

  property p_trim_up;
    @(posedge hclk) disable iff (!hresetn)
      (rail_valid && !mrg_on && s_r.mcfg.clmode == CL_TRIM && !s_r.mcfg.dir && rail_mv < s_r.nom &&
       s_r.mduty < MDUTY_MAX - MRG_STEP) |=> s_r.mduty == $past(s_r.mduty) + MRG_STEP;
  endproperty
  a_trim_up: assert property (p_trim_up) else $error("trim did not raise duty");

  property p_div_done;
    @(posedge hclk) disable iff (!hresetn)
      $fell(hreadyout) |-> ##[33:34] hreadyout;
  endproperty
  a_div_done: assert property (p_div_done) else $error("frequency write wait wrong length");

  property p_boundary;
    @(posedge hclk) disable iff (!hresetn)
      $changed(s_r.fduty_a[0]) |-> ({1'b0, $past(s_r.fcnt[0])} + FSTEP) >= {1'b0, $past(s_r.fdiv_a[0]), 1'b0};
  endproperty
  a_boundary: assert property (p_boundary) else $error("duty changed inside a period");
endmodule
`default_nettype wire

// >>> verif/pom_rail_model.sv
`timescale 1ns/1ps
`default_nettype none
// Rail behind the external RC filter, sampled by a slow converter
module pom_rail_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pwm,
  output logic [15:0] rail_mv,
  output logic rail_valid
);
  logic [3:0] tick_r; // Sample window counter
  logic [4:0] acc_r; // High cycles seen in the window
  // Average the margin pin over 15 of every 16 cycles, then report one sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_r <= 4'h0;
      acc_r <= 5'h00;
      rail_mv <= 16'h0400;
      rail_valid <= 1'b0;
    end else begin
      tick_r <= tick_r + 4'h1;
      acc_r <= (tick_r == 4'hF) ? 5'h00 : acc_r + {4'h0, pwm};
      rail_valid <= (tick_r == 4'hF);
      if (tick_r == 4'hF) begin
        rail_mv <= 16'h0400 + {7'h00, acc_r, 4'h0};
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/pwm_outputs_margining_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the PWM and margining block
module pwm_outputs_margining_tb_top;
  import pom_pkg::*;
  logic hclk = 1'b0; // Bus clock
  logic hresetn = 1'b0; // Bus reset
  logic hsel = 1'b0; // Slave select
  logic [31:0] haddr = 32'h0; // Address
  logic [1:0] htrans = 2'h0; // Transfer type
  logic hwrite = 1'b0; // Write flag
  logic [31:0] hwdata = 32'h0; // Write data
  logic [11:0] pin_in = 12'h000; // Pin levels
  wire logic [31:0] hrdata; // Read data
  wire logic hreadyout; // Slave ready, also the bus ready
  wire logic hresp; // Slave response
  wire logic [11:0] pin_out; // Pin drive levels
  wire logic [11:0] pin_oe_n; // Pin releases
  wire logic [15:0] rail_mv; // Rail sample
  wire logic rail_valid; // Rail sample strobe
  int n_errors = 0; // Mismatch count
  int compares = 0; // Comparison count
  int cycles = 0; // Timeout counter
  int seed = 32929; // Random seed
  logic [31:0] rd; // Last read word
  logic [31:0] r; // Random word
  logic [31:0] n; // High-cycle count of a pin
  int fr[5] = '{75000000, 0, 1000000000, 15260, 123457}; // Requested rates
  always #5 hclk = ~hclk;
  pom_top #(.PWM1_DIV(24'h000014), .PWM2_DIV(24'h000028)) pom_top_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .rail_mv(rail_mv), .rail_valid(rail_valid));
  pom_rail_model pom_rail_model_i (.hclk(hclk), .hresetn(hresetn), .pwm(pin_out[0]),
    .rail_mv(rail_mv), .rail_valid(rail_valid));
  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One single AHB transfer; read data taken at the closing edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask
  // Rounded quotient clamped to the divider range
  function automatic logic [31:0] divr(input longint src, input longint f, input longint mx);
    longint q;
    q = (f == 0) ? mx : (src + f / 2) / f;
    return (q < 2) ? 32'h2 : (q > mx) ? 32'(mx) : 32'(q);
  endfunction
  // Verdict and end of run
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("reset oe", {20'h0, pin_oe_n}, 32'h00000F00);
    chk("reset out", {20'h0, pin_out}, 32'h0);
    foreach (fr[i]) begin
      bus(1'b1, R_FAST_FREQ + 8'(4 * (i % 4)), fr[i]);
      bus(1'b0, R_FAST_FREQ + 8'(4 * (i % 4)), 32'h0);
      chk("fast div", rd, divr(250000000, fr[i], 16383));
      bus(1'b1, R_SLOW_FREQ + 8'(4 * (i % 2)), fr[i] / 64);
      bus(1'b0, R_SLOW_FREQ + 8'(4 * (i % 2)), 32'h0);
      chk("slow div", rd, divr(15625000, fr[i] / 64, 16777215));
    end
    bus(1'b1, R_MODE_FAST, 32'h00492492);
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      pin_in <= r[27:16];
      bus(1'b1, R_GPO, r);
      repeat (3) @(posedge hclk);
      chk("gpo out", {24'h0, pin_out[7:0]}, {24'h0, r[7:0]});
      chk("gpo oe", {24'h0, pin_oe_n[7:0]}, 32'h0);
      bus(1'b0, R_PIN_IN, 32'h0);
      chk("pin in", rd, {20'h0, r[27:16]});
    end
    // Slow pins 1 and 2 as PWM, 3 and 4 left as inputs
    bus(1'b1, R_MODE_SLOW, 32'h00000024);
    for (int c = 0; c < 2; c++) begin
      r = $random(seed);
      bus(1'b1, R_SLOW_DUTY + 8'(4 * c), {16'h0, r[15:0]});
      repeat (100) @(posedge hclk);
      n = 32'h0;
      // One full period of 20 or 40 cycles: high count is duty share of it
      repeat (20 * (c + 1)) begin
        @(posedge hclk);
        n = n + {31'h0, pin_out[NFAST + c]};
      end
      chk("slow duty", n, ({16'h0, r[15:0]} * (20 * (c + 1))) >> 16);
      chk("slow oe", {31'h0, pin_oe_n[NFAST + c]}, 32'h0);
    end
    bus(1'b0, 8'hFC, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, R_MODE_FAST, 32'h000000DD);
    bus(1'b1, R_MRG_FIXED, 32'h00012345);
    bus(1'b1, R_MRG_CTRL, 32'h00001FEC);
    repeat (4) @(posedge hclk);
    bus(1'b0, R_MRG_STAT, 32'h0);
    chk("fixed duty", rd, 32'h00012345);
    bus(1'b1, R_MRG_LOW, 32'h0000FFFF);
    bus(1'b1, R_MODE_FAST, 32'h000001BD);
    bus(1'b1, R_MRG_CTRL, 32'h00001FED);
    repeat (200) @(posedge hclk);
    bus(1'b0, R_MRG_STAT, 32'h0);
    chk("margin flags", {30'h0, rd[19:18]}, 32'h3);
    chk("duty rises", {31'h0, rd[17:0] > 18'h12345}, 32'h1);
    // Margin-down pin pulls while margining low, margin-up pin released
    chk("open loop", {30'h0, pin_oe_n[2:1]}, 32'h2);
    bus(1'b1, R_MRG_CTRL, 32'h00001FE4);
    repeat (40) @(posedge hclk);
    chk("tristate", {31'h0, pin_oe_n[0]}, 32'h1);
    // Active trim toward a high nominal raises the duty
    bus(1'b1, R_MRG_NOM, 32'h0000FFFF);
    bus(1'b0, R_MRG_STAT, 32'h0);
    r = rd;
    bus(1'b1, R_MRG_CTRL, 32'h00001FE8);
    repeat (100) @(posedge hclk);
    bus(1'b0, R_MRG_STAT, 32'h0);
    chk("trim rises", {31'h0, rd[17:0] > r[17:0]}, 32'h1);
    // Margining commanded by slow pins 3 (enable) and 4 (low)
    r = $random(seed);
    pin_in <= {r[1:0], 10'h000};
    bus(1'b1, R_MRG_CTRL, 32'h00001744);
    repeat (2) @(posedge hclk);
    bus(1'b0, R_MRG_STAT, 32'h0);
    chk("pin margin", {30'h0, rd[19:18]}, {30'h0, r[1:0]});
    // Pair 2 at divider 10: half duty, partner shifted half a period
    bus(1'b1, R_FAST_FREQ + 8'h04, 32'h017D7840);
    bus(1'b1, R_FAST_DUTY + 8'h08, 32'h00000050);
    bus(1'b1, R_FAST_DUTY + 8'h0C, 32'h00000050);
    bus(1'b1, R_FAST_PHASE + 8'h0C, 32'h00000005);
    bus(1'b1, R_MODE_FAST, 32'h0000011D);
    repeat (7000) @(posedge hclk);
    n = 32'h0;
    repeat (4) begin
      @(posedge hclk);
      n = n + {31'h0, pin_out[2]};
      chk("half phase", {31'h0, pin_out[2] ^ pin_out[3]}, 32'h1);
    end
    chk("fast duty", n, 32'h2);
    chk("partner oe", {31'h0, pin_oe_n[3]}, 32'h0);
    // Second reset in mid-run
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("rerun oe", {20'h0, pin_oe_n}, 32'h00000F00);
    bus(1'b0, R_FAST_FREQ, 32'h0);
    chk("reset div", rd, 32'h00003FFF);
    final_report();
  end
endmodule
`default_nettype wire
